// ---- hdl/timer_defines.svh ----
// register offsets, field positions and constants of the dual timer
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADR_TA_LOW 8'h00
`define ADR_TA_HIGH 8'h04
`define ADR_TB_LOW 8'h08
`define ADR_TB_HIGH 8'h0c
`define ADR_TCTRL 8'h10
`define ADR_TMODE 8'h14
`define ADR_CLKCTL 8'h18
`define ADR_EXTCFG 8'h1c
`define ADR_IRQEN 8'h20
`define ADR_IRQSTAT 8'h24
`define ADR_IRQCLR 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define TC_RUN_A 4
`define TC_OVF_A 5
`define TC_RUN_B 6
`define TC_OVF_B 7
`define TM_MODE_A_LO 0
`define TM_MODE_A_HI 1
`define TM_CSEL_A 2
`define TM_GATE_A 3
`define TM_MODE_B_LO 4
`define TM_MODE_B_HI 5
`define TM_CSEL_B 6
`define TM_GATE_B 7
`define CK_SCALE_LO 0
`define CK_SCALE_HI 1
`define CK_CLKSEL_A 2
`define CK_CLKSEL_B 3
`define EC_POL_A 3
`define EC_POL_B 7
`define IRQ_A 0
`define IRQ_B 1

// ----------------------------------------
// prescaler scale codes and reload values (divisor minus one)
// ----------------------------------------
`define SCALE_DIV12 2'h0
`define SCALE_DIV4 2'h1
`define SCALE_DIV48 2'h2
`define RELOAD_DIV12 6'h0b
`define RELOAD_DIV4 6'h03
`define RELOAD_DIV48 6'h2f
`define RELOAD_DIV8 6'h07

// ----------------------------------------
// count constants
// ----------------------------------------
`define CNT13_ONES 13'h1fff
`define CNT13_ZERO 13'h0000
`define CNT13_INC 13'h0001
`define CNT16_ONES 16'hffff
`define CNT16_INC 16'h0001
`define LOW8_ONES 8'hff
`define LOW8_INC 8'h01

`endif

// ---- hdl/timer_pkg.sv ----
// shared types of the dual timer
package timer_pkg;

  // primary operating modes selected by the mode_select_bits
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_HALTED = 2'b11
  } timer_mode_t;

endpackage

// ---- hdl/timer_unit.sv ----
// one counter/timer channel: source select, gating and the byte pair
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // configuration
  input wire timer_pkg::timer_mode_t mode_in,
  input wire logic counter_select_in,
  input wire logic clock_select_in,
  input wire logic run_in,
  input wire logic gate_enable_in,
  input wire logic gate_polarity_in,
  // count sources and gate
  input wire logic prescale_tick_in,
  input wire logic count_pin_in,
  input wire logic gate_input_in,
  // byte writes from software
  input wire logic wr_low_in,
  input wire logic wr_high_in,
  input wire logic [7:0] wr_data_in,
  // state
  output logic [7:0] low_byte_out,
  output logic [7:0] high_byte_out,
  output logic count_step_out,
  output logic overflow_out
);
  import timer_pkg::*;

  logic pin_prev_q;
  logic [7:0] low_q;
  logic [7:0] low_d;
  logic [7:0] high_q;
  logic [7:0] high_d;
  logic pin_fell;
  logic gate_active;
  logic enabled;
  logic source_tick;
  logic [12:0] cnt13;
  logic [12:0] sum13;
  logic [15:0] sum16;
  logic ovf_d;

  // ----------------------------------------
  // count source and gating
  // ----------------------------------------
  // one stored sample makes every high-then-low pair count once only
  assign pin_fell = pin_prev_q & ~count_pin_in;
  assign gate_active = (gate_input_in == gate_polarity_in);
  assign enabled = run_in & (~gate_enable_in | gate_active);
  // pin edges, system clock or prescaled tick
  assign source_tick = counter_select_in ? pin_fell : (clock_select_in ? 1'b1 : prescale_tick_in);
  // the split mode is not built here; a timer in it holds its count
  assign count_step_out = enabled & source_tick & (mode_in != MODE_HALTED);

  assign cnt13 = {high_q, low_q[4:0]};
  assign sum13 = cnt13 + `CNT13_INC;
  assign sum16 = {high_q, low_q} + `CNT16_INC;

  // ----------------------------------------
  // next count; a byte write wins over a step in the same cycle
  // ----------------------------------------
  always_comb begin
    low_d = low_q;
    high_d = high_q;
    ovf_d = 1'b0;
    if (count_step_out) begin
      unique case (mode_in)
        MODE_13BIT: begin
          // bits 7..5 of the low byte are left as they stand
          high_d = sum13[12:5];
          low_d[4:0] = sum13[4:0];
          ovf_d = (cnt13 == `CNT13_ONES);
        end
        MODE_16BIT: begin
          {high_d, low_d} = sum16;
          ovf_d = ({high_q, low_q} == `CNT16_ONES);
        end
        MODE_RELOAD8: begin
          low_d = (low_q == `LOW8_ONES) ? high_q : low_q + `LOW8_INC;
          ovf_d = (low_q == `LOW8_ONES);
        end
        MODE_HALTED: begin
          ovf_d = 1'b0;
        end
      endcase
    end
    if (wr_low_in) begin
      low_d = wr_data_in;
    end
    if (wr_high_in) begin
      high_d = wr_data_in;
    end
  end

  // ----------------------------------------
  // state registers; run never clears the count
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_prev_q <= 1'b0;
      low_q <= 8'h00;
      high_q <= 8'h00;
    end else begin
      pin_prev_q <= count_pin_in;
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  assign low_byte_out = low_q;
  assign high_byte_out = high_q;
  assign overflow_out = ovf_d;

endmodule // timer_unit

// ---- hdl/dual_timer.sv ----
// two counter/timers behind a classic wishbone slave with interrupt
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "timer_defines.svh"
module dual_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // timer pins
  input wire logic timer_a_count_pin_in,
  input wire logic timer_b_count_pin_in,
  input wire logic gate_input_a_in,
  input wire logic gate_input_b_in,
  // interrupt
  output logic irq_out
);
  import timer_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic timer_a_run_q;
  logic timer_b_run_q;
  logic [7:0] timer_mode_reg_q;
  logic [7:0] clock_control_reg_q;
  logic [7:0] ext_irq_config_reg_q;
  logic [1:0] interrupt_enable_reg_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_status_d;
  logic [5:0] prescale_q;
  logic [5:0] prescale_reload;
  logic prescale_tick;
  logic bus_req;
  logic bus_wr;
  logic hit_ta_lo;
  logic hit_ta_hi;
  logic hit_tb_lo;
  logic hit_tb_hi;
  logic hit_tctrl;
  logic hit_tmode;
  logic hit_clkctl;
  logic hit_extcfg;
  logic hit_irqen;
  logic hit_irqstat;
  logic hit_irqclr;
  logic [7:0] rd_byte;
  logic [7:0] timer_control_reg;
  logic [1:0] clear_mask;
  logic [1:0] overflow_set;
  logic [7:0] timer_a_low_byte;
  logic [7:0] timer_a_high_byte;
  logic [7:0] timer_b_low_byte;
  logic [7:0] timer_b_high_byte;
  logic step_a;
  logic step_b;
  logic timer_a_overflow_flag;
  logic timer_b_overflow_flag;
  logic wr_ta_lo;
  logic wr_ta_hi;
  logic wr_tb_lo;
  logic wr_tb_hi;

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  // writes land at the edge that samples ack, so the master sees them then
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign bus_wr = bus_req & wb_we_in & ack_q & wb_sel_in[0];
  assign hit_ta_lo = (wb_adr_in == `ADR_TA_LOW);
  assign hit_ta_hi = (wb_adr_in == `ADR_TA_HIGH);
  assign hit_tb_lo = (wb_adr_in == `ADR_TB_LOW);
  assign hit_tb_hi = (wb_adr_in == `ADR_TB_HIGH);
  assign hit_tctrl = (wb_adr_in == `ADR_TCTRL);
  assign hit_tmode = (wb_adr_in == `ADR_TMODE);
  assign hit_clkctl = (wb_adr_in == `ADR_CLKCTL);
  assign hit_extcfg = (wb_adr_in == `ADR_EXTCFG);
  assign hit_irqen = (wb_adr_in == `ADR_IRQEN);
  assign hit_irqstat = (wb_adr_in == `ADR_IRQSTAT);
  assign hit_irqclr = (wb_adr_in == `ADR_IRQCLR);
  assign wr_ta_lo = bus_wr & hit_ta_lo;
  assign wr_ta_hi = bus_wr & hit_ta_hi;
  assign wr_tb_lo = bus_wr & hit_tb_lo;
  assign wr_tb_hi = bus_wr & hit_tb_hi;

  // overflow flags shown in the control register beside the run bits
  assign timer_control_reg = {timer_b_overflow_flag, timer_b_run_q, timer_a_overflow_flag, timer_a_run_q, 4'h0};

  // read selection; the clear register and unmapped words read zero
  assign rd_byte = hit_ta_lo ? timer_a_low_byte :
                   hit_ta_hi ? timer_a_high_byte :
                   hit_tb_lo ? timer_b_low_byte :
                   hit_tb_hi ? timer_b_high_byte :
                   hit_tctrl ? timer_control_reg :
                   hit_tmode ? timer_mode_reg_q :
                   hit_clkctl ? clock_control_reg_q :
                   hit_extcfg ? ext_irq_config_reg_q :
                   hit_irqen ? {6'h00, interrupt_enable_reg_q} :
                   hit_irqstat ? {6'h00, irq_status_q} : 8'h00;

  // one wait state: ack rises a cycle after the request and drops after one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_a_run_q <= 1'b0;
      timer_b_run_q <= 1'b0;
      timer_mode_reg_q <= 8'h00;
      clock_control_reg_q <= 8'h00;
      ext_irq_config_reg_q <= 8'h00;
      interrupt_enable_reg_q <= 2'h0;
    end else if (bus_wr) begin
      if (hit_tctrl) begin
        // flag bits here are read-only; they clear through the clear word
        timer_a_run_q <= wb_dat_in[`TC_RUN_A];
        timer_b_run_q <= wb_dat_in[`TC_RUN_B];
      end
      if (hit_tmode) begin
        timer_mode_reg_q <= wb_dat_in[7:0];
      end
      if (hit_clkctl) begin
        clock_control_reg_q <= wb_dat_in[7:0];
      end
      if (hit_extcfg) begin
        ext_irq_config_reg_q <= wb_dat_in[7:0];
      end
      if (hit_irqen) begin
        interrupt_enable_reg_q <= wb_dat_in[1:0];
      end
    end
  end

  // ----------------------------------------
  // shared prescaler
  // ----------------------------------------
  assign prescale_reload =
    (clock_control_reg_q[`CK_SCALE_HI:`CK_SCALE_LO] == `SCALE_DIV12) ? `RELOAD_DIV12 :
    (clock_control_reg_q[`CK_SCALE_HI:`CK_SCALE_LO] == `SCALE_DIV4) ? `RELOAD_DIV4 :
    (clock_control_reg_q[`CK_SCALE_HI:`CK_SCALE_LO] == `SCALE_DIV48) ? `RELOAD_DIV48 : `RELOAD_DIV8;
  assign prescale_tick = (prescale_q == 6'h00);

  // free running; a new scale takes effect at the next terminal count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale_q <= 6'h00;
    end else begin
      prescale_q <= prescale_tick ? prescale_reload : prescale_q - 6'h01;
    end
  end

  // ----------------------------------------
  // the two timers, each with its own bits and pins
  // ----------------------------------------
  timer_unit u_timer_a (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mode_in(timer_mode_t'(timer_mode_reg_q[`TM_MODE_A_HI:`TM_MODE_A_LO])),
    .counter_select_in(timer_mode_reg_q[`TM_CSEL_A]),
    .clock_select_in(clock_control_reg_q[`CK_CLKSEL_A]),
    .run_in(timer_a_run_q),
    .gate_enable_in(timer_mode_reg_q[`TM_GATE_A]),
    .gate_polarity_in(ext_irq_config_reg_q[`EC_POL_A]),
    .prescale_tick_in(prescale_tick),
    .count_pin_in(timer_a_count_pin_in),
    .gate_input_in(gate_input_a_in),
    .wr_low_in(wr_ta_lo),
    .wr_high_in(wr_ta_hi),
    .wr_data_in(wb_dat_in[7:0]),
    .low_byte_out(timer_a_low_byte),
    .high_byte_out(timer_a_high_byte),
    .count_step_out(step_a),
    .overflow_out(overflow_set[`IRQ_A])
  );

  timer_unit u_timer_b (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mode_in(timer_mode_t'(timer_mode_reg_q[`TM_MODE_B_HI:`TM_MODE_B_LO])),
    .counter_select_in(timer_mode_reg_q[`TM_CSEL_B]),
    .clock_select_in(clock_control_reg_q[`CK_CLKSEL_B]),
    .run_in(timer_b_run_q),
    .gate_enable_in(timer_mode_reg_q[`TM_GATE_B]),
    .gate_polarity_in(ext_irq_config_reg_q[`EC_POL_B]),
    .prescale_tick_in(prescale_tick),
    .count_pin_in(timer_b_count_pin_in),
    .gate_input_in(gate_input_b_in),
    .wr_low_in(wr_tb_lo),
    .wr_high_in(wr_tb_hi),
    .wr_data_in(wb_dat_in[7:0]),
    .low_byte_out(timer_b_low_byte),
    .high_byte_out(timer_b_high_byte),
    .count_step_out(step_b),
    .overflow_out(overflow_set[`IRQ_B])
  );

  // ----------------------------------------
  // sticky overflow flags and interrupt
  // ----------------------------------------
  // a wrap in the same cycle as its clear keeps the flag set
  assign clear_mask = (bus_wr & hit_irqclr) ? wb_dat_in[1:0] : 2'h0;
  assign irq_status_d = (irq_status_q & ~clear_mask) | overflow_set;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_status_q <= 2'h0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  assign timer_a_overflow_flag = irq_status_q[`IRQ_A];
  assign timer_b_overflow_flag = irq_status_q[`IRQ_B];
  assign irq_out = |(irq_status_q & interrupt_enable_reg_q);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [12:0] cnt_a;
  logic [12:0] cnt_b;
  logic pin_a_prev_q;
  assign cnt_a = {timer_a_high_byte, timer_a_low_byte[4:0]};
  assign cnt_b = {timer_b_high_byte, timer_b_low_byte[4:0]};

  // helper sample of the count pin for the edge check
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_a_prev_q <= 1'b0;
    end else begin
      pin_a_prev_q <= timer_a_count_pin_in;
    end
  end

  sequence s_a_mode13_free;
    (timer_mode_reg_q[`TM_MODE_A_HI:`TM_MODE_A_LO] == MODE_13BIT) && !wr_ta_lo && !wr_ta_hi;
  endsequence

  sequence s_a_wraps;
    s_a_mode13_free ##0 step_a && (cnt_a == `CNT13_ONES);
  endsequence

  a_wrap_sets_flag: assert property (s_a_wraps |=> (cnt_a == `CNT13_ZERO) && timer_a_overflow_flag)
    else $error("timer a wrap did not clear count and set flag");

  a_irq_masked: assert property (timer_a_overflow_flag && !interrupt_enable_reg_q[`IRQ_A]
    && !(timer_b_overflow_flag && interrupt_enable_reg_q[`IRQ_B]) |-> !irq_out)
    else $error("interrupt raised for a disabled timer");

  a_irq_enabled: assert property (timer_b_overflow_flag && interrupt_enable_reg_q[`IRQ_B] |-> irq_out)
    else $error("enabled timer b flag gave no interrupt");

  a_run_off_hold: assert property (!timer_a_run_q && !wr_ta_lo && !wr_ta_hi |=> $stable(cnt_a))
    else $error("timer a moved while not running");

  a_gate_blocks: assert property (timer_a_run_q && timer_mode_reg_q[`TM_GATE_A]
    && (gate_input_a_in != ext_irq_config_reg_q[`EC_POL_A]) |-> !step_a)
    else $error("timer a counted with its gate inactive");

  a_sysclk_step: assert property (s_a_mode13_free ##0 timer_a_run_q && !timer_mode_reg_q[`TM_GATE_A]
    && !timer_mode_reg_q[`TM_CSEL_A] && clock_control_reg_q[`CK_CLKSEL_A]
    |=> cnt_a == $past(cnt_a) + `CNT13_INC)
    else $error("timer a missed a system clock step");

  a_pin_edge: assert property (s_a_mode13_free ##0 timer_a_run_q && !timer_mode_reg_q[`TM_GATE_A]
    && timer_mode_reg_q[`TM_CSEL_A] && pin_a_prev_q && !timer_a_count_pin_in
    |=> cnt_a == $past(cnt_a) + `CNT13_INC)
    else $error("timer a missed a count pin falling edge");

  a_pin_level: assert property (timer_mode_reg_q[`TM_CSEL_A] && step_a
    |-> pin_a_prev_q && !timer_a_count_pin_in)
    else $error("timer a counted without a falling edge");

  a_prescale_only: assert property (!timer_mode_reg_q[`TM_CSEL_A] && !clock_control_reg_q[`CK_CLKSEL_A]
    && !prescale_tick |-> !step_a)
    else $error("timer a counted between prescaler ticks");

  a_run_keeps_count: assert property ($rose(timer_a_run_q) && $past(!wr_ta_lo && !wr_ta_hi)
    |-> cnt_a == $past(cnt_a))
    else $error("setting run changed the count");

  a_low_top_kept: assert property (s_a_mode13_free |=> $stable(timer_a_low_byte[7:5]))
    else $error("low byte upper bits changed by counting");

  a_b_independent: assert property (!timer_b_run_q && !wr_tb_lo && !wr_tb_hi |=> $stable(cnt_b))
    else $error("timer b moved while not running");

  a_ack_single: assert property (bus_req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("wishbone ack not a single cycle after the request");

endmodule // dual_timer

// ---- sim/pin_model.sv ----
// partner model of the external count pins and gate inputs
`timescale 1ns/1ps
module pin_model (
  // clock
  input wire logic clk_in,
  // pins towards the timers
  output logic count_a_out,
  output logic count_b_out,
  output logic gate_a_out,
  output logic gate_b_out
);
  // count pins idle high, so only commanded low phases make falling edges
  initial begin
    count_a_out = 1'b1;
    count_b_out = 1'b1;
    gate_a_out = 1'b0;
    gate_b_out = 1'b0;
  end
  // two edges low, two edges high: the timer always sees two low samples and at least two high ones
  task automatic pulse(input bit sel_b, input int n);
    repeat (n) begin
      @(posedge clk_in);
      count_a_out <= sel_b | 1'b0;
      count_b_out <= ~sel_b;
      repeat (2) @(posedge clk_in);
      count_a_out <= 1'b1;
      count_b_out <= 1'b1;
      repeat (2) @(posedge clk_in);
    end
  endtask
  // gate levels change right after an edge and stay until told otherwise
  task automatic set_gates(input logic ga, input logic gb);
    @(posedge clk_in);
    gate_a_out <= ga;
    gate_b_out <= gb;
  endtask
endmodule // pin_model

// ---- sim/tb_top.sv ----
// self-checking bench of the dual timer against an integer count model
`timescale 1ns/1ps
`include "timer_defines.svh"
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [3:0] sel_v = 4'h1;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq;
  logic cnt_a, cnt_b, gate_a, gate_b;
  logic [31:0] rv, hv;
  int n_errors = 0;
  int check_count = 0;
  int seed = 92;
  int cyc_n = 0;
  int tw, t0, m_a, m_b, n;

  // ----------------------------------------
  // clock, design and pin partner
  // ----------------------------------------
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) cyc_n <= cyc_n + 1;
  dual_timer i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .timer_a_count_pin_in(cnt_a), .timer_b_count_pin_in(cnt_b),
    .gate_input_a_in(gate_a), .gate_input_b_in(gate_b), .irq_out(irq));
  pin_model i_pins (.clk_in(clk_in), .count_a_out(cnt_a), .count_b_out(cnt_b), .gate_a_out(gate_a),
    .gate_b_out(gate_b));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is seen high, take data at that edge, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= sel_v;
    wb_dat <= d;
    do @(posedge clk_in); while (wb_ack !== 1'b1);
    rv = wb_rdat;
    tw = cyc_n;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h0, d});
  endtask
  // upper three low-byte bits are not part of the count and are masked
  task automatic cnt_chk(input bit b, input int exp);
    wb(1'b0, b ? `ADR_TB_HIGH : `ADR_TA_HIGH, 32'h0);
    hv = rv;
    wb(1'b0, b ? `ADR_TB_LOW : `ADR_TA_LOW, 32'h0);
    chk("count13", {19'h0, hv[7:0], rv[4:0]}, exp);
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge clk_in);
    chk("irq_out", {31'h0, irq}, {31'h0, exp});
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs only a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    // every register reads zero after reset, unmapped places read zero too
    for (int a = 0; a <= 'h30; a += 4) begin
      wb(1'b0, a[7:0], 32'h0);
      chk("reset value", rv, 32'h0);
    end
    wr(8'h30, 8'h5a);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped", rv, 32'h0);
    // timer a: pin source, gated, gate active high, loaded close to the wrap
    m_a = 'h1ff8 + ($random(seed) & 3);
    wr(`ADR_TMODE, 8'h0c);
    wr(`ADR_EXTCFG, 8'h08);
    wr(`ADR_TA_LOW, {3'b101, m_a[4:0]});
    wr(`ADR_TA_HIGH, m_a[12:5]);
    wr(`ADR_TCTRL, 8'h10);
    for (int g = 0; g < 2; g++) begin
      i_pins.set_gates(g[0], 1'b0);
      n = g ? 8 + ($random(seed) & 7) : 3;
      i_pins.pulse(1'b0, n);
      m_a = g ? (m_a + n) & 'h1fff : m_a;
      cnt_chk(1'b0, m_a);
    end
    cnt_chk(1'b1, 0);
    wb(1'b0, `ADR_TCTRL, 32'h0);
    chk("control", rv, 32'h30);
    irq_chk(1'b0);
    wr(`ADR_IRQEN, 8'h01);
    irq_chk(1'b1);
    wr(`ADR_IRQCLR, 8'h01);
    irq_chk(1'b0);
    // stopped timer ignores pins, restart resumes from the held count
    wr(`ADR_TCTRL, 8'h00);
    i_pins.pulse(1'b0, 2);
    wr(`ADR_TCTRL, 8'h10);
    i_pins.pulse(1'b0, 1);
    m_a = (m_a + 1) & 'h1fff;
    cnt_chk(1'b0, m_a);
    // timer b on the system clock: one step per edge while run is set
    wr(`ADR_TCTRL, 8'h00);
    wr(`ADR_CLKCTL, 8'h08);
    m_b = 'h1ffe;
    wr(`ADR_TB_LOW, 8'h1e);
    wr(`ADR_TB_HIGH, 8'hff);
    wr(`ADR_TCTRL, 8'h40);
    t0 = tw;
    wr(`ADR_TCTRL, 8'h00);
    m_b = (m_b + tw - t0) & 'h1fff;
    cnt_chk(1'b1, m_b);
    wb(1'b0, `ADR_IRQSTAT, 32'h0);
    chk("status", rv, 32'h2);
    wr(`ADR_IRQEN, 8'h02);
    irq_chk(1'b1);
    wr(`ADR_IRQCLR, 8'h02);
    irq_chk(1'b0);
    // timer b on its pin with gate active low: high gate blocks, low gate counts
    wr(`ADR_TMODE, 8'hcc);
    wr(`ADR_TCTRL, 8'h40);
    for (int g = 1; g >= 0; g--) begin
      i_pins.set_gates(1'b0, g[0]);
      i_pins.pulse(1'b1, 3);
      m_b = g ? m_b : (m_b + 3) & 'h1fff;
      cnt_chk(1'b1, m_b);
    end
    // both timers at once: a on the system clock, b on the prescaled tick
    // scale code 0 divides by 12; the first tick is the edge after reset release
    // (cycle count 20), so later ticks fall where the cycle count is 8 modulo 12
    wr(`ADR_TCTRL, 8'h00);
    wr(`ADR_TMODE, 8'h00);
    wr(`ADR_CLKCTL, 8'h04);
    wr(`ADR_TCTRL, 8'h50);
    t0 = tw;
    repeat (20 + ($random(seed) & 15)) @(posedge clk_in);
    wr(`ADR_TCTRL, 8'h00);
    m_a = (m_a + tw - t0) & 'h1fff;
    for (int k = t0 + 1; k <= tw; k++) begin
      if (k % 12 == 8) begin
        m_b = (m_b + 1) & 'h1fff;
      end
    end
    cnt_chk(1'b0, m_a);
    cnt_chk(1'b1, m_b);
    // a write without byte lane zero is acked but changes nothing
    sel_v = 4'h0;
    wr(`ADR_TA_HIGH, 8'h77);
    sel_v = 4'h1;
    cnt_chk(1'b0, m_a);
    end_sim;
  end
endmodule // tb_top
